// ==== hw/lpmcg_pkg.sv ====
// Constants shared by the power-mode clock gating controller.
// Assumes a single 25 MHz system clock and an active-low asynchronous reset.
package lpmcg_pkg;

    // ------------------------------------------------------------------------
    // Operating states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        active_state,
        sleep_level_0,
        sleep_level_1,
        sleep_level_2,
        sleep_level_3,
        sleep_level_4,
        sleep_level_4_5
    } lpmcg_mode_t;

    // Encoded sleep request presented by the CPU.
    localparam logic [2:0] REQ_ACTIVE = 3'h0;
    localparam logic [2:0] REQ_LVL0   = 3'h1;
    localparam logic [2:0] REQ_LVL1   = 3'h2;
    localparam logic [2:0] REQ_LVL2   = 3'h3;
    localparam logic [2:0] REQ_LVL3   = 3'h4;
    localparam logic [2:0] REQ_LVL4   = 3'h5;
    localparam logic [2:0] REQ_LVL4_5 = 3'h6;

    // ------------------------------------------------------------------------
    // Vector table
    // ------------------------------------------------------------------------
    localparam logic [15:0] VEC_BASE    = 16'hff80;
    localparam logic [15:0] VEC_TOP     = 16'hffff;
    localparam logic [15:0] VEC_RESET   = 16'hfffe;
    localparam int          VEC_ENTRIES = 64;
    localparam int          VEC_IDX_W   = 6;
    localparam int          ADDR_W      = 16;

    // Reset values of the enables: everything running.
    localparam logic [7:0] EN_RESET = 8'hff;

endpackage

// ==== hw/lpmcg_vec_mem.sv ====
// Vector table memory: one 16-bit handler address per word entry.
// Assumes the writer loads entries while the CPU is running; read data is registered.
`timescale 1ns/100ps
`default_nettype none
module lpmcg_vec_mem #(
    parameter int DEPTH = 64,
    parameter int AW    = 6,
    parameter int DW    = 16
) (
    input  wire logic          clk,      // System clock.
    input  wire logic          wr_en,    // Write strobe.
    input  wire logic [AW-1:0] wr_idx,   // Entry written.
    input  wire logic [DW-1:0] wr_data,  // Handler address written.
    input  wire logic          rd_en,    // Read strobe.
    input  wire logic [AW-1:0] rd_idx,   // Entry read.
    output logic      [DW-1:0] rd_data   // Registered handler address.
);

    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_idx];
        end
    end

endmodule
`default_nettype wire

// ==== hw/lpmcg_ctrl.sv ====
// What this block does
// - One active state and six software-chosen sleep levels, seven states in all.
// - Active state runs main, sub-system and auxiliary clocks.
// - Level 0 stops CPU and main clock; auxiliary, sub-system, loop keep running.
// - Level 1 also stops loop control; auxiliary and sub-system clocks run.
// - Level 2 also stops oscillator clock; dc generator and auxiliary clock stay.
// - Level 4 also stops sub-system clock, auxiliary clock and crystal; data retained.
// - Level 4.5 turns regulator off; only reset/NMI or ports one/two wake.
// - Interrupt wakes from levels 0 to 4; handler return restores previous level.
// - Vectors and start address sit at ff80h..ffffh, each a 16-bit handler address.
//
// Power-mode controller: gates CPU and clock sources per selected sleep level.
// Assumes request, wake and return inputs are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module lpmcg_ctrl #(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk,             // System clock, 25 MHz.
    input  wire logic              resetn,          // Asynchronous reset, active low.
    input  wire logic              sleep_req,       // CPU strobe: enter requested level.
    input  wire logic [2:0]        sleep_sel,       // Encoded requested level.
    input  wire logic              irq_any,         // Any enabled interrupt pending.
    input  wire logic              nmi_wake,        // Reset/NMI pin event.
    input  wire logic              port_one_wake,   // Port one edge event.
    input  wire logic              port_two_wake,   // Port two edge event.
    input  wire logic              irq_return,      // CPU returning from handler.
    input  wire logic [5:0]        irq_vec_idx,     // Word index of serviced vector.
    input  wire logic              vec_wr,          // Vector table write strobe.
    input  wire logic [ADDR_W-1:0] vec_wr_data,     // Vector table write data.
    output logic                   cpu_en,          // CPU enabled.
    output logic                   main_clk_en,     // Main CPU clock gate.
    output logic                   sub_system_clock_en, // Sub-system clock gate.
    output logic                   aux_clk_en,      // Auxiliary clock gate.
    output logic                   frequency_locked_loop_en, // Loop control on.
    output logic                   controlled_oscillator_clock_en, // Oscillator clock.
    output logic                   osc_dc_gen_en,   // Oscillator dc generator on.
    output logic                   crystal_en,      // Crystal oscillator on.
    output logic                   regulator_en,    // Internal regulator on.
    output logic                   data_retained,   // Stored data is valid.
    output logic [2:0]             mode_state,      // Current operating state.
    output logic [ADDR_W-1:0]      vec_addr,        // Address of vector slot.
    output logic [ADDR_W-1:0]      handler_addr,    // Handler address read.
    output logic                   handler_valid    // handler_addr valid pulse.
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    lpmcg_pkg::lpmcg_mode_t mode_reg, mode_next;
    lpmcg_pkg::lpmcg_mode_t saved_reg, saved_next;
    logic [7:0]             en_reg, en_next;
    logic                   reg_on_reg, reg_on_next;
    logic                   keep_reg, keep_next;
    logic [ADDR_W-1:0]      vaddr_reg, vaddr_next;
    logic                   rd_pend_reg, rd_pend_next;
    logic                   hv_reg, hv_next;
    logic [ADDR_W-1:0]      mem_rd;
    logic                   wake;

    function automatic lpmcg_pkg::lpmcg_mode_t decode(input logic [2:0] sel);
        lpmcg_pkg::lpmcg_mode_t m;
        m = lpmcg_pkg::active_state;
        case (sel)
            lpmcg_pkg::REQ_LVL0:   m = lpmcg_pkg::sleep_level_0;
            lpmcg_pkg::REQ_LVL1:   m = lpmcg_pkg::sleep_level_1;
            lpmcg_pkg::REQ_LVL2:   m = lpmcg_pkg::sleep_level_2;
            lpmcg_pkg::REQ_LVL3:   m = lpmcg_pkg::sleep_level_3;
            lpmcg_pkg::REQ_LVL4:   m = lpmcg_pkg::sleep_level_4;
            lpmcg_pkg::REQ_LVL4_5: m = lpmcg_pkg::sleep_level_4_5;
            default:               m = lpmcg_pkg::active_state;
        endcase
        return m;
    endfunction

    // Enable vector order: {crystal, dcgen, osc clk, loop, aux, sub, main, cpu}.
    function automatic logic [7:0] enables(input lpmcg_pkg::lpmcg_mode_t m);
        logic [7:0] e;
        e = lpmcg_pkg::EN_RESET;
        case (m)
            lpmcg_pkg::active_state:    e = 8'hff;
            lpmcg_pkg::sleep_level_0:   e = 8'hfc;
            lpmcg_pkg::sleep_level_1:   e = 8'hec;
            lpmcg_pkg::sleep_level_2:   e = 8'hcc;
            lpmcg_pkg::sleep_level_3:   e = 8'h8c;
            lpmcg_pkg::sleep_level_4:   e = 8'h00;
            lpmcg_pkg::sleep_level_4_5: e = 8'h00;
            default:                    e = 8'hff;
        endcase
        return e;
    endfunction

    // ------------------------------------------------------------------------
    // Wake qualification
    // ------------------------------------------------------------------------
    // In the deepest level the interrupt logic is unpowered, so only the
    // reset/NMI pin and the two port groups can bring the device back.
    always_comb begin
        if (mode_reg == lpmcg_pkg::sleep_level_4_5) begin
            wake = nmi_wake | port_one_wake | port_two_wake;
        end else begin
            wake = irq_any | nmi_wake;
        end
    end

    // ------------------------------------------------------------------------
    // Mode sequencing
    // ------------------------------------------------------------------------
    // A handler return outranks a new sleep request in the same cycle, and is
    // ignored unless a level was saved, so a stray return changes nothing.
    always_comb begin
        mode_next   = mode_reg;
        saved_next  = saved_reg;
        reg_on_next = reg_on_reg;
        keep_next   = keep_reg;
        if (mode_reg != lpmcg_pkg::active_state) begin
            if (wake) begin
                mode_next   = lpmcg_pkg::active_state;
                reg_on_next = 1'b1;
                if (mode_reg == lpmcg_pkg::sleep_level_4_5) begin
                    // Waking from shutdown is a restart: nothing to return to.
                    saved_next = lpmcg_pkg::active_state;
                end else begin
                    saved_next = mode_reg;
                end
            end
        end else if (irq_return && saved_reg != lpmcg_pkg::active_state) begin
            mode_next  = saved_reg;
            saved_next = lpmcg_pkg::active_state;
        end else if (sleep_req) begin
            mode_next = decode(sleep_sel);
            if (decode(sleep_sel) == lpmcg_pkg::sleep_level_4_5) begin
                reg_on_next = 1'b0;
                keep_next   = 1'b0;
            end else begin
                // Entering any other level straight after a restart must
                // already report retention, not one cycle late.
                keep_next = 1'b1;
            end
        end
        if (mode_reg == lpmcg_pkg::active_state && mode_next == lpmcg_pkg::active_state) begin
            keep_next = 1'b1;
        end
        if (mode_reg == lpmcg_pkg::sleep_level_4) begin
            keep_next = 1'b1;
        end
        en_next = enables(mode_next);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_reg   <= lpmcg_pkg::active_state;
            saved_reg  <= lpmcg_pkg::active_state;
            en_reg     <= lpmcg_pkg::EN_RESET;
            reg_on_reg <= 1'b1;
            keep_reg   <= 1'b0;
        end else begin
            mode_reg   <= mode_next;
            saved_reg  <= saved_next;
            en_reg     <= en_next;
            reg_on_reg <= reg_on_next;
            keep_reg   <= keep_next;
        end
    end

    // ------------------------------------------------------------------------
    // Vector table access
    // ------------------------------------------------------------------------
    // Entry 63 is the power-up start address; lower entries descend by word.
    always_comb begin
        vaddr_next   = lpmcg_pkg::VEC_BASE | ADDR_W'({irq_vec_idx, 1'b0});
        // Only a wake that leaves a sleep level starts a fetch, so an interrupt
        // held pending in the active state cannot hold handler_valid high.
        rd_pend_next = wake && (mode_reg != lpmcg_pkg::active_state);
        hv_next      = rd_pend_reg;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vaddr_reg   <= lpmcg_pkg::VEC_RESET;
            rd_pend_reg <= 1'b0;
            hv_reg      <= 1'b0;
        end else begin
            vaddr_reg   <= vaddr_next;
            rd_pend_reg <= rd_pend_next;
            hv_reg      <= hv_next;
        end
    end

    lpmcg_vec_mem #(
        .DEPTH (lpmcg_pkg::VEC_ENTRIES),
        .AW    (lpmcg_pkg::VEC_IDX_W),
        .DW    (ADDR_W)
    ) u_vec (
        .clk     (clk),
        .wr_en   (vec_wr),
        .wr_idx  (irq_vec_idx),
        .wr_data (vec_wr_data),
        .rd_en   (rd_pend_reg),
        .rd_idx  (vaddr_reg[6:1]),
        .rd_data (mem_rd)
    );

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign cpu_en                         = en_reg[0];
    assign main_clk_en                    = en_reg[1];
    assign sub_system_clock_en            = en_reg[2];
    assign aux_clk_en                     = en_reg[3];
    assign frequency_locked_loop_en       = en_reg[4];
    assign controlled_oscillator_clock_en = en_reg[5];
    assign osc_dc_gen_en                  = en_reg[6];
    assign crystal_en                     = en_reg[7];
    assign regulator_en                   = reg_on_reg;
    assign data_retained                  = keep_reg;
    assign mode_state                     = mode_reg;
    assign vec_addr                       = vaddr_reg;
    assign handler_addr                   = mem_rd;
    assign handler_valid                  = hv_reg;

endmodule
`default_nettype wire

// ==== sim/lpmcg_props.sv ====
// Checker for the power-mode controller: enables per state, entry, wake and vectors.
// Assumes it is bound to lpmcg_ctrl and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module lpmcg_props (
    input wire logic        clk,                            // Clock.
    input wire logic        resetn,                         // Reset, active low.
    input wire logic        sleep_req,                      // Entry strobe.
    input wire logic [2:0]  sleep_sel,                      // Requested level.
    input wire logic        irq_any,                        // Interrupt.
    input wire logic        nmi_wake,                       // Pin event.
    input wire logic        port_one_wake,                  // Port event.
    input wire logic        port_two_wake,                  // Port event.
    input wire logic        irq_return,                     // Handler return.
    input wire logic        cpu_en,                         // Gate.
    input wire logic        main_clk_en,                    // Gate.
    input wire logic        sub_system_clock_en,            // Gate.
    input wire logic        aux_clk_en,                     // Gate.
    input wire logic        frequency_locked_loop_en,       // Gate.
    input wire logic        controlled_oscillator_clock_en, // Gate.
    input wire logic        osc_dc_gen_en,                  // Gate.
    input wire logic        crystal_en,                     // Gate.
    input wire logic        regulator_en,                   // Regulator.
    input wire logic        data_retained,                  // Retention.
    input wire logic [2:0]  mode_state,                     // State.
    input wire logic [15:0] vec_addr,                       // Vector slot.
    input wire logic        handler_valid                   // Read pulse.
);
    logic [7:0] en;
    assign en = {crystal_en, osc_dc_gen_en, controlled_oscillator_clock_en,
        frequency_locked_loop_en, aux_clk_en, sub_system_clock_en, main_clk_en, cpu_en};
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    property p_active; mode_state == 3'h0 |-> en == 8'hff; endproperty
    property p_lvl0; mode_state == 3'h1 |-> en == 8'hfc; endproperty
    property p_lvl1; mode_state == 3'h2 |-> en == 8'hec; endproperty
    property p_lvl2; mode_state == 3'h3 |-> en == 8'hcc; endproperty
    property p_lvl3; mode_state == 3'h4 |-> en == 8'h8c; endproperty
    property p_lvl4; mode_state == 3'h5 |-> en == 8'h00 && data_retained && regulator_en;
    endproperty
    property p_lvl45; mode_state == 3'h6 |-> en == 8'h00 && !regulator_en && !data_retained;
    endproperty
    property p_range; mode_state <= 3'h6; endproperty
    property p_enter; mode_state == 3'h0 && sleep_req && !irq_return && sleep_sel inside {[1:6]}
        |=> mode_state == $past(sleep_sel); endproperty
    property p_wake; mode_state inside {[1:5]} && (irq_any || nmi_wake)
        |=> mode_state == 3'h0 && en == 8'hff; endproperty
    property p_deep_hold; mode_state == 3'h6 && !(nmi_wake || port_one_wake || port_two_wake)
        |=> mode_state == 3'h6; endproperty
    property p_vec; vec_addr[15:7] == 9'h1ff && !vec_addr[0]; endproperty
    property p_fetch; (mode_state inside {[1:5]} && (irq_any || nmi_wake)) ||
        (mode_state == 3'h6 && (nmi_wake || port_one_wake || port_two_wake))
        |-> ##2 handler_valid; endproperty
    a_active: assert property (p_active) else $error("active enables wrong");
    a_lvl0: assert property (p_lvl0) else $error("level 0 enables wrong");
    a_lvl1: assert property (p_lvl1) else $error("level 1 enables wrong");
    a_lvl2: assert property (p_lvl2) else $error("level 2 enables wrong");
    a_lvl3: assert property (p_lvl3) else $error("level 3 enables wrong");
    a_lvl4: assert property (p_lvl4) else $error("level 4 outputs wrong");
    a_lvl45: assert property (p_lvl45) else $error("level 4.5 outputs wrong");
    a_range: assert property (p_range) else $error("state out of range");
    a_enter: assert property (p_enter) else $error("request not applied");
    a_wake: assert property (p_wake) else $error("wake not accepted");
    a_deep_hold: assert property (p_deep_hold) else $error("level 4.5 left wrongly");
    a_vec: assert property (p_vec) else $error("vector slot outside table");
    a_fetch: assert property (p_fetch) else $error("handler fetch missing");
    c_deep: cover property (mode_state == 3'h6 ##1 mode_state == 3'h0);
    c_wake: cover property (mode_state inside {[1:5]} ##1 mode_state == 3'h0);
    c_ret: cover property (mode_state == 3'h0 && irq_return ##1 mode_state != 3'h0);
endmodule
bind lpmcg_ctrl lpmcg_props i_lpmcg_props (.*);
`default_nettype wire

// ==== sim/lpmcg_cpu_model.sv ====
// CPU side model: returns from the handler some cycles after the vector read.
// Assumes handler_valid is a one-cycle pulse and ret_dly is held stable.
`timescale 1ns/100ps
`default_nettype none
module lpmcg_cpu_model (
    input  wire logic       clk,           // System clock.
    input  wire logic       handler_valid, // Vector read done.
    input  wire logic       ret_en,        // Return after this wake.
    input  wire logic [3:0] ret_dly,       // Handler length in cycles.
    output var  logic       irq_return     // Return pulse.
);
    initial begin
        irq_return = 1'b0;
        forever begin
            @(posedge clk);
            if (handler_valid === 1'b1 && ret_en === 1'b1) begin
                repeat (ret_dly) @(posedge clk);
                #1 irq_return = 1'b1;
                @(posedge clk);
                #1 irq_return = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/lpmcg_tb.sv ====
// Testbench for the power-mode controller with a CPU side model.
// Assumes lpmcg_ctrl holds the vector table and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
module lpmcg_tb;
    logic clk = 1'b0, resetn = 1'b0, sleep_req = 1'b0, irq_any = 1'b0, nmi_wake = 1'b0;
    logic port_one_wake = 1'b0, port_two_wake = 1'b0, vec_wr = 1'b0, ret_en = 1'b0;
    logic [2:0] sleep_sel = 3'h0;
    logic [5:0] irq_vec_idx = 6'h00;
    logic [15:0] vec_wr_data = 16'h0000;
    logic [3:0] ret_dly = 4'h0;
    logic cpu_en, main_clk_en, sub_system_clock_en, aux_clk_en, frequency_locked_loop_en;
    logic controlled_oscillator_clock_en, osc_dc_gen_en, crystal_en, regulator_en;
    logic data_retained, handler_valid, irq_return;
    logic [2:0] mode_state;
    logic [15:0] vec_addr, handler_addr;
    logic [7:0] en;
    logic [2:0] lvl;
    int mismatches = 0, cmp_count = 0, k, n;
    assign en = {crystal_en, osc_dc_gen_en, controlled_oscillator_clock_en,
        frequency_locked_loop_en, aux_clk_en, sub_system_clock_en, main_clk_en, cpu_en};
    always #20 clk = ~clk;
    lpmcg_ctrl i_lpmcg_ctrl (.*);
    lpmcg_cpu_model i_lpmcg_cpu_model (.clk(clk), .handler_valid(handler_valid),
        .ret_en(ret_en), .ret_dly(ret_dly), .irq_return(irq_return));
    function automatic logic [7:0] en_of(input logic [2:0] m);
        case (m)
            3'h1: return 8'hfc;
            3'h2: return 8'hec;
            3'h3: return 8'hcc;
            3'h4: return 8'h8c;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [15:0] vdata(input logic [5:0] i);
        return 16'ha5c0 ^ {i, 4'h3, i};
    endfunction
    task automatic wrap_up;
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic enter(input logic [2:0] s);
        sleep_sel = s;
        sleep_req = 1'b1;
        step;
        sleep_req = 1'b0;
        step;
    endtask
    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        void'($urandom(32'h9dbd_0cb5));
        repeat (8) @(posedge clk);
        #1 resetn = 1'b1;
        chk("reset enables", en, 8'hff);
        chk("reset vector", vec_addr, 16'hfffe);
        for (k = 0; k < 64; k++) begin
            vec_wr = 1'b1;
            irq_vec_idx = 6'(k);
            vec_wr_data = vdata(6'(k));
            step;
        end
        vec_wr = 1'b0;
        enter(3'h0);
        enter(3'h7);
        chk("unused code", mode_state, 3'h0);
        for (n = 0; n < 20; n++) begin
            lvl = (n < 6) ? 3'(n + 1) : 3'($urandom_range(1, 6));
            irq_vec_idx = 6'($urandom_range(0, 63));
            ret_dly = 4'($urandom_range(0, 7));
            enter(lvl);
            chk("mode", mode_state, lvl);
            chk("enables", en, en_of(lvl));
            chk("slot", vec_addr, 16'hff80 | {irq_vec_idx, 1'b0});
            if (lvl == 3'h5) chk("retained", data_retained, 1'b1);
            enter(3'h1 + lvl % 3'h6);
            chk("refused", mode_state, lvl);
            if (lvl == 3'h6) begin
                chk("regulator", regulator_en, 1'b0);
                irq_any = 1'b1;
                step;
                irq_any = 1'b0;
                chk("irq ignored", mode_state, 3'h6);
                k = $urandom_range(0, 2);
                nmi_wake = (k == 0);
                port_one_wake = (k == 1);
                port_two_wake = (k == 2);
            end else begin
                ret_en = 1'b1;
                if ($urandom_range(0, 1) == 1) irq_any = 1'b1;
                else nmi_wake = 1'b1;
            end
            step;
            {irq_any, nmi_wake, port_one_wake, port_two_wake} = 4'h0;
            chk("wake", mode_state, 3'h0);
            chk("regulator on", regulator_en, 1'b1);
            for (k = 0; k < 10 && handler_valid !== 1'b1; k++) step;
            chk("handler valid", handler_valid, 1'b1);
            if (handler_valid !== 1'b1) wrap_up();
            chk("handler", handler_addr, vdata(irq_vec_idx));
            if (lvl != 3'h6) begin
                for (k = 0; k < 40 && mode_state !== lvl; k++) step;
                chk("restored", mode_state, lvl);
                if (mode_state !== lvl) wrap_up();
                ret_en = 1'b0;
                nmi_wake = 1'b1;
                step;
                nmi_wake = 1'b0;
                chk("rewake", en, 8'hff);
            end
            repeat (4) step;
        end
        enter(3'h3);
        resetn = 1'b0;
        #1 chk("mid reset", {mode_state, en}, {3'h0, 8'hff});
        chk("mid reset power", {regulator_en, data_retained, handler_valid}, 3'b100);
        chk("mid reset vector", vec_addr, 16'hfffe);
        step;
        resetn = 1'b1;
        step;
        chk("retained after reset", data_retained, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
